// ==== logic/twsm_bit_engine.sv ====
module twsm_bit_engine
  import twsm_pkg::*;
#(
  parameter int QUARTER = QUARTER_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  twsm_bit_if.eng bus,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic scl_oe_o,
  output logic sda_o,
  output logic sda_oe_o
);
  localparam int CW = $clog2(QUARTER + 1);

  if (QUARTER < 2) begin : g_bad_quarter
    $error("twsm_bit_engine: QUARTER must be at least 2");
  end

  logic scl_meta, scl_sync, sda_meta, sda_sync;
  logic busy, next_busy;
  logic [1:0] ph, next_ph;
  logic [CW-1:0] div, next_div;
  twsm_bop_e op, next_op;
  logic wbit, next_wbit, done, next_done, rbit, next_rbit;
  logic next_scl_oe, next_sda_oe;

  // Pull-low pattern {scl, sda} for each quarter of a bit operation
  function automatic logic [1:0] drive(input twsm_bop_e o, input logic [1:0] p, input logic b);
    logic [1:0] r;
    r = 2'b00;
    unique case (o)
      BOP_START: r = (p == 2'd0) ? 2'b10 : (p == 2'd1) ? 2'b00 : (p == 2'd2) ? 2'b01 : 2'b11;
      BOP_STOP: r = (p == 2'd0) ? 2'b11 : (p == 2'd3) ? 2'b00 : 2'b01;
      BOP_WRITE: r = {(p == 2'd0) || (p == 2'd3), ~b};
      BOP_READ: r = {(p == 2'd0) || (p == 2'd3), 1'b0};
    endcase
    return r;
  endfunction

  always_comb begin
    next_busy = busy;
    next_ph = ph;
    next_div = div;
    next_op = op;
    next_wbit = wbit;
    next_done = 1'b0;
    next_rbit = rbit;
    next_scl_oe = scl_oe_o;
    next_sda_oe = sda_oe_o;
    if (!busy) begin
      if (bus.req) begin
        next_busy = 1'b1;
        next_ph = 2'd0;
        next_op = bus.op;
        next_wbit = bus.wbit;
        next_div = CW'(QUARTER - 1);
        {next_scl_oe, next_sda_oe} = drive(bus.op, 2'd0, bus.wbit);
      end
    end else if (div != '0) begin
      next_div = div - CW'(1);
    end else begin
      next_div = CW'(QUARTER - 1);
      if (ph == 2'd3) begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end else if (!(ph == 2'd1 && !scl_sync)) begin
        // A slave holding scl low stretches the high phase
        next_ph = ph + 2'd1;
        {next_scl_oe, next_sda_oe} = drive(op, ph + 2'd1, wbit);
        if (ph == 2'd2) begin
          next_rbit = sda_sync;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    scl_meta <= scl_i;
    scl_sync <= scl_meta;
    sda_meta <= sda_i;
    sda_sync <= sda_meta;
    if (rst_i) begin
      busy <= 1'b0;
      ph <= 2'd0;
      div <= '0;
      op <= BOP_START;
      wbit <= 1'b0;
      done <= 1'b0;
      rbit <= 1'b0;
      scl_oe_o <= 1'b0;
      sda_oe_o <= 1'b0;
    end else begin
      busy <= next_busy;
      ph <= next_ph;
      div <= next_div;
      op <= next_op;
      wbit <= next_wbit;
      done <= next_done;
      rbit <= next_rbit;
      scl_oe_o <= next_scl_oe;
      sda_oe_o <= next_sda_oe;
    end
    scl_o <= 1'b0;
    sda_o <= 1'b0;
  end

  assign bus.done = done;
  assign bus.rbit = rbit;
endmodule

// ==== logic/twsm_bit_if.sv ====
interface twsm_bit_if;
  import twsm_pkg::*;
  logic req;
  twsm_bop_e op;
  logic wbit;
  logic done;
  logic rbit;
  modport ctrl (output req, op, wbit, input done, rbit);
  modport eng (input req, op, wbit, output done, rbit);
endinterface

// ==== logic/twsm_pkg.sv ====
package twsm_pkg;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int SCL_PERIOD_NS = 10000;
  // Least quarter bit time, rounded up to whole clock cycles
  localparam int QUARTER_CYC = (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
  localparam int DATA_W = 8;
  localparam int ADR_W = 8;
  localparam logic [3:0] BIT_LAST = 4'h8;

  // ---------------------------------------------------------------
  // Register map, byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] ADR_DATA = 8'h00;
  localparam logic [7:0] ADR_CMD = 8'h04;
  localparam logic [7:0] ADR_ACK_CTRL = 8'h08;
  localparam logic [7:0] ADR_STATUS = 8'h0C;
  localparam logic [7:0] ADR_INT_STATUS = 8'h10;
  localparam logic [7:0] ADR_INT_CLEAR = 8'h14;
  localparam logic [7:0] ADR_INT_ENABLE = 8'h18;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int CMD_RECV = 0;
  localparam int CMD_SEND = 1;
  localparam int CMD_START = 2;
  localparam int CMD_STOP = 3;
  localparam int FL_NACK = 0;
  localparam int FL_TXFIN = 1;
  localparam int FL_RXFIN = 2;
  localparam int FL_CMDFIN = 3;
  localparam int ACK_SEL = 0;
  localparam logic [3:0] CMD_RST = 4'h0;
  localparam logic [3:0] STATUS_RST = 4'h0;
  localparam logic [3:0] INT_RST = 4'h0;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic ACK_RST = 1'b0;

  typedef enum logic [1:0] {BOP_START, BOP_STOP, BOP_WRITE, BOP_READ} twsm_bop_e;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_ISSUE, SEQ_WAIT} twsm_seq_e;
endpackage

// ==== logic/twsm_top.sv ====
// What this block does
// - After a received byte, drive ACK when ack select set, else NACK.
// - Bytes to send and bytes received share one data register.
// - Start and stop command bits clear once the condition is generated.
// - After a send, a status flag shows whether the slave gave NACK.
// - Stop command performs a stop segment, the follow-up after NACK.
// - All command bits clear means no segment; the bus is left as it is, held low after a start or a byte.
// - Command done sets on start or stop finish, clears at next activity.
// - Transmit and receive done flags set per byte, clear at next activity.
// - Each command bit is cleared by hardware when its segment completes.
module twsm_top
  import twsm_pkg::*;
#(
  parameter int QUARTER = QUARTER_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic irq_o
);
  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] shared_data_reg, next_shared_data_reg;
  logic [3:0] segment_command_reg, next_segment_command_reg;
  logic ack_control_reg, next_ack_control_reg;
  logic [3:0] segment_status_reg, next_segment_status_reg;
  logic [3:0] int_status, next_int_status;
  logic [3:0] int_enable, next_int_enable;
  logic [31:0] next_wb_dat;
  logic next_wb_ack, next_irq;

  twsm_seq_e seq, next_seq;
  logic [3:0] seg_mask, next_seg_mask;
  logic [3:0] bit_cnt, next_bit_cnt;

  logic bus_acc, bus_wr;
  logic [ADR_W-1:0] word_adr;
  logic seg_begin, seg_fin;
  logic tx_nack_ev, rx_bit_ev;
  logic [3:0] int_ev;
  twsm_bop_e issue_op;
  logic issue_wbit;

  twsm_bit_if bit_link ();

  // ---------------------------------------------------------------
  // Command decoding
  // ---------------------------------------------------------------
  function automatic logic is_onehot(input logic [3:0] c);
    return (c != 4'h0) && ((c & (c - 4'h1)) == 4'h0);
  endfunction

  function automatic logic is_byte_seg(input logic [3:0] m);
    return m[CMD_SEND] || m[CMD_RECV];
  endfunction

  // ---------------------------------------------------------------
  // Segment sequencer
  // ---------------------------------------------------------------
  always_comb begin
    next_seq = seq;
    next_seg_mask = seg_mask;
    next_bit_cnt = bit_cnt;
    seg_begin = 1'b0;
    seg_fin = 1'b0;
    unique case (seq)
      SEQ_IDLE: begin
        // Zero or several bits set: the bus is left alone
        if (is_onehot(segment_command_reg)) begin
          next_seg_mask = segment_command_reg;
          next_bit_cnt = 4'h0;
          next_seq = SEQ_ISSUE;
          seg_begin = 1'b1;
        end
      end
      SEQ_ISSUE: begin
        next_seq = SEQ_WAIT;
      end
      SEQ_WAIT: begin
        if (bit_link.done) begin
          if (!is_byte_seg(seg_mask) || bit_cnt == BIT_LAST) begin
            seg_fin = 1'b1;
            next_seq = SEQ_IDLE;
          end else begin
            next_bit_cnt = bit_cnt + 4'h1;
            next_seq = SEQ_ISSUE;
          end
        end
      end
    endcase
  end

  // One bit operation per issue; the ninth slot of a byte is the acknowledge
  always_comb begin
    issue_op = BOP_READ;
    issue_wbit = 1'b1;
    if (seg_mask[CMD_START]) begin
      issue_op = BOP_START;
    end else if (seg_mask[CMD_STOP]) begin
      issue_op = BOP_STOP;
    end else if (seg_mask[CMD_SEND]) begin
      if (bit_cnt == BIT_LAST) begin
        issue_op = BOP_READ;
      end else begin
        issue_op = BOP_WRITE;
        issue_wbit = shared_data_reg[3'(4'h7 - bit_cnt)];
      end
    end else if (bit_cnt == BIT_LAST) begin
      issue_op = BOP_WRITE;
      issue_wbit = ~ack_control_reg;
    end
  end

  assign bit_link.req = (seq == SEQ_ISSUE);
  assign bit_link.op = issue_op;
  assign bit_link.wbit = issue_wbit;

  assign tx_nack_ev = bit_link.done && seq == SEQ_WAIT && seg_mask[CMD_SEND]
                      && bit_cnt == BIT_LAST && bit_link.rbit;
  assign rx_bit_ev = bit_link.done && seq == SEQ_WAIT && seg_mask[CMD_RECV]
                     && bit_cnt != BIT_LAST;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seq <= SEQ_IDLE;
      seg_mask <= CMD_RST;
      bit_cnt <= 4'h0;
    end else begin
      seq <= next_seq;
      seg_mask <= next_seg_mask;
      bit_cnt <= next_bit_cnt;
    end
  end

  // ---------------------------------------------------------------
  // Bit engine
  // ---------------------------------------------------------------
  twsm_bit_engine #(
    .QUARTER(QUARTER)
  ) u_engine (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .bus(bit_link),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .scl_o(scl_o),
    .scl_oe_o(scl_oe_o),
    .sda_o(sda_o),
    .sda_oe_o(sda_oe_o)
  );

  // ---------------------------------------------------------------
  // Register file and Wishbone slave
  // ---------------------------------------------------------------
  assign bus_acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign bus_wr = bus_acc && wb_we_i && wb_sel_i[0];
  assign word_adr = {wb_adr_i[ADR_W-1:2], 2'b00};

  assign int_ev[FL_CMDFIN] = seg_fin && !is_byte_seg(seg_mask);
  assign int_ev[FL_TXFIN] = seg_fin && seg_mask[CMD_SEND];
  assign int_ev[FL_RXFIN] = seg_fin && seg_mask[CMD_RECV];
  assign int_ev[FL_NACK] = tx_nack_ev;

  always_comb begin
    next_shared_data_reg = shared_data_reg;
    next_segment_command_reg = segment_command_reg;
    next_ack_control_reg = ack_control_reg;
    next_segment_status_reg = segment_status_reg;
    next_int_status = int_status & ~((bus_wr && word_adr == ADR_INT_CLEAR)
                                     ? wb_dat_i[3:0] : 4'h0);
    next_int_enable = int_enable;
    next_wb_ack = bus_acc;
    next_wb_dat = 32'h0000_0000;

    // Completed segment drops its own command bit
    if (seg_fin) begin
      next_segment_command_reg = segment_command_reg & ~seg_mask;
    end
    if (bus_wr) begin
      case (word_adr)
        ADR_DATA: next_shared_data_reg = wb_dat_i[DATA_W-1:0];
        ADR_CMD: next_segment_command_reg = wb_dat_i[3:0];
        ADR_ACK_CTRL: next_ack_control_reg = wb_dat_i[ACK_SEL];
        ADR_INT_ENABLE: next_int_enable = wb_dat_i[3:0];
        default: begin
        end
      endcase
    end
    if (rx_bit_ev) begin
      next_shared_data_reg = {shared_data_reg[DATA_W-2:0], bit_link.rbit};
    end

    // Flags clear as a new segment starts
    if (seg_begin) begin
      next_segment_status_reg = STATUS_RST;
    end
    if (tx_nack_ev) begin
      next_segment_status_reg[FL_NACK] = 1'b1;
    end
    if (int_ev[FL_CMDFIN]) begin
      next_segment_status_reg[FL_CMDFIN] = 1'b1;
    end
    if (int_ev[FL_TXFIN]) begin
      next_segment_status_reg[FL_TXFIN] = 1'b1;
    end
    if (int_ev[FL_RXFIN]) begin
      next_segment_status_reg[FL_RXFIN] = 1'b1;
    end

    // An event in the same cycle as its clear stays set
    next_int_status = next_int_status | int_ev;
    next_irq = |(next_int_status & next_int_enable);

    if (bus_acc && !wb_we_i) begin
      case (word_adr)
        ADR_DATA: next_wb_dat = {24'h00_0000, shared_data_reg};
        ADR_CMD: next_wb_dat = {28'h000_0000, segment_command_reg};
        ADR_ACK_CTRL: next_wb_dat = {31'h0000_0000, ack_control_reg};
        ADR_STATUS: next_wb_dat = {28'h000_0000, segment_status_reg};
        ADR_INT_STATUS: next_wb_dat = {28'h000_0000, int_status};
        ADR_INT_ENABLE: next_wb_dat = {28'h000_0000, int_enable};
        default: next_wb_dat = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shared_data_reg <= DATA_RST;
      segment_command_reg <= CMD_RST;
      ack_control_reg <= ACK_RST;
      segment_status_reg <= STATUS_RST;
      int_status <= INT_RST;
      int_enable <= INT_RST;
      wb_dat_o <= 32'h0000_0000;
      wb_ack_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      shared_data_reg <= next_shared_data_reg;
      segment_command_reg <= next_segment_command_reg;
      ack_control_reg <= next_ack_control_reg;
      segment_status_reg <= next_segment_status_reg;
      int_status <= next_int_status;
      int_enable <= next_int_enable;
      wb_dat_o <= next_wb_dat;
      wb_ack_o <= next_wb_ack;
      irq_o <= next_irq;
    end
  end
endmodule

// ==== test/twsm_slave_model.sv ====
module twsm_slave_model #(
  parameter logic [7:0] REPLY = 8'hC3
) (
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic rd_mode_i,
  input wire logic nack_i,
  output logic sda_oe_o,
  output logic [7:0] rx_byte_o,
  output logic mst_nack_o,
  output logic stop_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------------
  // Wire-level slave
  // ---------------------------------------------------------------
  logic [3:0] cnt = 4'h0;
  initial begin
    sda_oe_o = 1'b0;
    rx_byte_o = 8'h00;
    mst_nack_o = 1'b0;
    stop_o = 1'b0;
  end
  always @(negedge sda_i) begin
    if (scl_i) begin
      cnt = 4'h0;
      mst_nack_o = 1'b0;
      stop_o = 1'b0;
    end
  end
  always @(posedge sda_i) begin
    if (scl_i) stop_o = 1'b1;
  end
  always @(posedge scl_i) begin
    if (cnt == 4'h8) begin
      mst_nack_o = sda_i;
      cnt = 4'h0;
    end else begin
      rx_byte_o = {rx_byte_o[6:0], sda_i};
      cnt = cnt + 4'h1;
    end
  end
  // Changes only while the clock is low; after a master NACK it lets go, as a real slave does
  always @(negedge scl_i) begin
    if (rd_mode_i) sda_oe_o = (cnt < 4'h8) && !mst_nack_o && !REPLY[3'(4'h7 - cnt)];
    else sda_oe_o = (cnt == 4'h8) && !nack_i;
  end
endmodule

// ==== test/twsm_top_props.sv ====
module twsm_top_props
  import twsm_pkg::*;
#(
  parameter int QUARTER = QUARTER_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe_o,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic irq_o
);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  logic taken;
  logic wr_cmd;
  logic idle;
  logic cmd_seen;
  logic next_cmd_seen;
  assign taken = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_cmd = taken && wb_we_i && wb_sel_i[0] && wb_adr_i == ADR_CMD;
  // Only a released, high bus counts, so a write while either line is pulled low or reads low is not judged
  assign idle = scl_i && sda_i && !scl_oe_o && !sda_oe_o;
  always_comb begin
    next_cmd_seen = cmd_seen || wr_cmd;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_seen <= 1'b0;
    end else begin
      cmd_seen <= next_cmd_seen;
    end
  end
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_next_cycle: assert property (taken |=> wb_ack_o)
    else $error("access not answered in one cycle");
  a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside ack");
  a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i[7:2] > 6'h6
    |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_open_drain_low: assert property (scl_o == 1'b0 && sda_o == 1'b0)
    else $error("pin output not low");
  a_reset_releases: assert property ($fell(rst_i) |-> !scl_oe_o && !sda_oe_o)
    else $error("bus not released after reset");
  a_idle_no_cmd: assert property (!cmd_seen |-> !scl_oe_o && !sda_oe_o)
    else $error("bus driven before any command");
  a_illegal_quiet: assert property (wr_cmd && !$onehot(wb_dat_i[3:0]) && idle
    |=> (!scl_oe_o && !sda_oe_o) [*8])
    else $error("bus driven for non single command");
  a_irq_masked: assert property (taken && wb_we_i && wb_sel_i[0]
    && wb_adr_i == ADR_INT_ENABLE && wb_dat_i[3:0] == 4'h0 |-> ##2 !irq_o)
    else $error("irq high with all sources masked");
  a_irq_cleared: assert property (taken && wb_we_i && wb_sel_i[0]
    && wb_adr_i == ADR_INT_CLEAR && wb_dat_i[3:0] == 4'hF |-> ##2 !irq_o)
    else $error("irq high after full clear");
  c_start: cover property (wr_cmd && wb_dat_i[3:0] == 4'h4);
  c_stop: cover property (wr_cmd && wb_dat_i[3:0] == 4'h8);
  c_illegal: cover property (wr_cmd && !$onehot(wb_dat_i[3:0]) && idle);
  c_irq: cover property ($rose(irq_o));
endmodule

bind twsm_top twsm_top_props #(.QUARTER(QUARTER)) twsm_top_props_inst (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .scl_i(scl_i), .scl_o(scl_o),
  .scl_oe_o(scl_oe_o), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .irq_o(irq_o)
);

// ==== test/twsm_top_tb.sv ====
module twsm_top_tb
  import twsm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------------
  // Harness
  // ---------------------------------------------------------------
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [ADR_W-1:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o, rd;
  logic wb_ack_o, scl_o, scl_oe_o, sda_o, sda_oe_o, irq_o, s_oe, nack_bit, saw_stop;
  logic rd_mode = 1'b0;
  logic give_nack = 1'b0;
  logic [7:0] rx_byte;
  int failures = 0;
  int tests_run = 0;
  int act = 0;
  // Pull-ups: a released line reads high, never a held-over value
  wire scl_w = !(scl_oe_o === 1'b1);
  wire sda_w = !(sda_oe_o === 1'b1 || s_oe === 1'b1);
  always #50 clk_i = ~clk_i;
  always @(posedge clk_i) if (scl_oe_o === 1'b1 || sda_oe_o === 1'b1) act <= act + 1;
  // Four quarters of two clocks give 800 ns; the scl sync stall in quarter 1 and the two issue cycles make the link clock period 1200 ns
  twsm_top #(.QUARTER(2)) twsm_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .scl_i(scl_w),
    .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .irq_o(irq_o));
  twsm_slave_model twsm_slave_model_inst (.scl_i(scl_w), .sda_i(sda_w), .rd_mode_i(rd_mode),
    .nack_i(give_nack), .sda_oe_o(s_oe), .rx_byte_o(rx_byte), .mst_nack_o(nack_bit),
    .stop_o(saw_stop));
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic close_out();
    $display("comparisons=%0d mismatches=%0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 20) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      close_out();
    end
  endtask
  // Polls the command bit, as software would, under a bounded count
  task automatic run(input logic [3:0] cmd);
    int n;
    n = 0;
    wb(1'b1, ADR_CMD, {28'h0, cmd});
    do begin
      wb(1'b0, ADR_CMD, 32'h0);
      n++;
    end while (rd !== 32'h0 && n < 300);
    chk(rd, 32'h0);
    if (rd !== 32'h0) close_out();
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    for (int a = 0; a < 8; a++) begin
      wb(1'b0, 8'(a * 4), 32'h0);
      chk(rd, 32'h0);
    end
    chk({30'h0, scl_oe_o, sda_oe_o}, 32'h0);
  endtask
  task automatic t_illegal();
    int a0;
    a0 = act;
    wb(1'b1, ADR_CMD, 32'h6);
    repeat (60) @(posedge clk_i);
    wb(1'b0, ADR_CMD, 32'h0);
    chk(rd, 32'h6);
    wb(1'b1, ADR_CMD, 32'h0);
    repeat (30) @(posedge clk_i);
    chk(32'(act - a0), 32'h0);
  endtask
  task automatic t_start();
    wb(1'b1, ADR_INT_ENABLE, 32'hF);
    run(4'h4);
    wb(1'b0, ADR_STATUS, 32'h0);
    chk(rd, 32'h8);
    chk({31'h0, irq_o}, 32'h1);
    wb(1'b1, ADR_INT_CLEAR, 32'hF);
    @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h0);
  endtask
  task automatic t_send();
    logic [7:0] b [4] = '{8'h54, 8'hF4, 8'h5B, 8'hA5};
    for (int i = 0; i < 4; i++) begin
      give_nack <= (i == 3);
      wb(1'b1, ADR_DATA, {24'h0, b[i]});
      run(4'h2);
      chk({24'h0, rx_byte}, {24'h0, b[i]});
      wb(1'b0, ADR_STATUS, 32'h0);
      chk(rd, (i == 3) ? 32'h3 : 32'h2);
    end
  endtask
  task automatic t_recv();
    rd_mode <= 1'b1;
    give_nack <= 1'b0;
    run(4'h4);
    for (int i = 0; i < 2; i++) begin
      wb(1'b1, ADR_ACK_CTRL, 32'(i == 0));
      run(4'h1);
      wb(1'b0, ADR_DATA, 32'h0);
      chk(rd, 32'hC3);
      chk({31'h0, nack_bit}, 32'(i));
      wb(1'b0, ADR_STATUS, 32'h0);
      chk(rd, 32'h4);
    end
  endtask
  task automatic t_stop();
    run(4'h8);
    chk({31'h0, saw_stop}, 32'h1);
    chk({30'h0, scl_oe_o, sda_oe_o}, 32'h0);
    wb(1'b0, ADR_STATUS, 32'h0);
    chk(rd, 32'h8);
    wb(1'b1, ADR_INT_ENABLE, 32'h0);
    @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h0);
    wb(1'b1, ADR_INT_ENABLE, 32'h8);
    @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h1);
    wb(1'b1, ADR_INT_CLEAR, 32'hF);
    @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h0);
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_illegal();
    t_start();
    t_send();
    t_recv();
    t_stop();
    close_out();
  end
endmodule
